// *** core/twx_map.svh ***
/*
  Constant map for the table-write / test-skip / xor execution block.
  Assumes inclusion by bare name from the package, the address former and the core module.
*/
`ifndef TWX_MAP_SVH
`define TWX_MAP_SVH
// Opcode patterns, upper bits of the 16-bit instruction word
`define TWX_TABWR_HI   14'h0003
`define TWX_TSTZ_HI    7'h33
`define TWX_XORLIT_HI  8'h0a
`define TWX_XORREG_HI  6'h06
// Pointer modes taken from the two low opcode bits
`define TWX_PM_NONE    2'h0
`define TWX_PM_POSTINC 2'h1
`define TWX_PM_POSTDEC 2'h2
`define TWX_PM_PREINC  2'h3
// Indexed literal offset ceiling
`define TWX_IDX_MAX    8'h5f
// Access bank split point
`define TWX_ACC_SPLIT  8'h60
// Bank of the upper access half
`define TWX_ACC_HIBANK 4'hf
// Reset values, zero byte and pointer step
`define TWX_W_RST      8'h00
`define TWX_PTR_RST    21'h000000
`define TWX_ZERO8      8'h00
`define TWX_ONE_PTR    21'h000001
`endif

// *** core/twx_pkg.sv ***
/*
  Types for the table-write / test-skip / xor execution block.
  Assumes the constant map header is on the include path.
*/
package twx_pkg;
  `include "twx_map.svh"
  // Operation decoded from the instruction word
  typedef enum logic [2:0] {TWX_OP_NONE, TWX_OP_TABWR, TWX_OP_TST,
                            TWX_OP_XORL, TWX_OP_XORF} twx_op_t;
  // Data-memory request towards the file register array
  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  data;
  } twx_fmem_t;
  // Holding-register write towards program memory
  typedef struct packed {
    logic        wr;
    logic [20:0] addr;
    logic [7:0]  data;
  } twx_hold_t;
endpackage

// *** core/twx_addr.sv ***
/*
  Operand address former for file-register instructions.
  Assumes operands arrive from the same clock domain; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "twx_map.svh"
module twx_addr
  import twx_pkg::*;
(
  // Operand fields
  input  wire logic [7:0]  i_f,
  input  wire logic        i_a,
  // Core context
  input  wire logic [3:0]  i_bank_select_reg,
  input  wire logic        i_ext_set_en,
  input  wire logic [11:0] i_index_base,
  // Formed address
  output logic      [11:0] o_addr,
  output logic             o_indexed
);
  // Indexed literal offset only in access mode with extension on
  assign o_indexed = !i_a && i_ext_set_en && (i_f <= `TWX_IDX_MAX);
  // Access bank: low part in bank 0, high part in the top bank
  wire [11:0] acc_addr = (i_f < `TWX_ACC_SPLIT) ? {4'h0, i_f}
                                                : {`TWX_ACC_HIBANK, i_f};
  // Banked form takes the bank from the bank select register
  wire [11:0] bank_addr = {i_bank_select_reg, i_f};
  // Sum cut to the data space on purpose: a base near the top wraps
  wire [11:0] idx_addr  = 12'(i_index_base + {4'h0, i_f});
  assign o_addr = o_indexed ? idx_addr : (i_a ? bank_addr : acc_addr);
endmodule
`default_nettype wire

// *** core/twx_core.sv ***
/*
  Execution unit for table write, test-and-skip-if-zero, and both xor forms.
  Assumes a one-cycle-per-instruction strobe from the fetch unit, a file
  register array answering reads combinationally, and an external table
  write path on variants that have the external memory interface.
*/
`timescale 1ns/1ps
`default_nettype none
`include "twx_map.svh"
module twx_core
  import twx_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  // Instruction issue
  input  wire logic        i_valid,
  input  wire logic [15:0] i_instr,
  // Configuration straps, same domain
  input  wire logic        i_has_ext_bus,
  input  wire logic        i_target_external,
  input  wire logic        i_ext_set_en,
  input  wire logic [3:0]  i_bank_select_reg,
  input  wire logic [11:0] i_index_base,
  input  wire logic [7:0]  i_table_latch,
  // File register read data
  input  wire logic [7:0]  i_fmem_rdata,
  // Outputs
  output logic      [11:0] o_fmem_raddr,
  output twx_fmem_t        o_fmem,
  output twx_hold_t        o_hold,
  output logic      [20:0] o_table_pointer,
  output logic      [7:0]  o_working_reg,
  output logic             o_flag_n,
  output logic             o_flag_z,
  output logic             o_flush,
  output logic             o_busy,
  output logic             o_illegal
);
  // Decoded op
  twx_op_t op;
  // Registered state
  logic [20:0] ptr_q;
  logic [7:0]  w_q;
  logic        n_q;
  logic        z_q;
  logic        flush_q;
  logic        busy_q;
  logic        illegal_q;
  twx_fmem_t   fmem_q;
  twx_hold_t   hold_q;

  // Decode by opcode patterns
  wire is_tabwr = (i_instr[15:2] == `TWX_TABWR_HI);
  wire is_tst   = (i_instr[15:9] == `TWX_TSTZ_HI);
  wire is_xorl  = (i_instr[15:8] == `TWX_XORLIT_HI);
  wire is_xorf  = (i_instr[15:10] == `TWX_XORREG_HI);
  // Busy second cycle drops new issue; fetch unit holds it
  wire issue    = i_valid && !busy_q;
  assign op = !issue ? TWX_OP_NONE :
              is_tabwr ? TWX_OP_TABWR :
              is_tst   ? TWX_OP_TST :
              is_xorl  ? TWX_OP_XORL :
              is_xorf  ? TWX_OP_XORF : TWX_OP_NONE;

  // Operand fields: f is 8 bits, a is 1 bit, so range holds by width
  wire [7:0] f_fld = i_instr[7:0];
  wire       a_fld = i_instr[8];
  wire       d_fld = i_instr[9];
  wire [1:0] pmode = i_instr[1:0];

  // Shared address former
  logic [11:0] faddr;
  twx_addr twx_addr_inst
  (
    .i_f               (f_fld),
    .i_a               (a_fld),
    .i_bank_select_reg (i_bank_select_reg),
    .i_ext_set_en      (i_ext_set_en),
    .i_index_base      (i_index_base),
    .o_addr            (faddr),
    .o_indexed         ()
  );
  assign o_fmem_raddr = faddr;

  // Table writes permitted only with the external bus and target
  wire tw_ok = i_has_ext_bus && i_target_external;

  // Pointer step by mode
  function automatic logic [20:0] step_ptr(input logic [20:0] p,
                                           input logic [1:0] m);
    case (m)
      `TWX_PM_POSTINC: step_ptr = 21'(p + `TWX_ONE_PTR);
      `TWX_PM_POSTDEC: step_ptr = 21'(p - `TWX_ONE_PTR);
      `TWX_PM_PREINC:  step_ptr = 21'(p + `TWX_ONE_PTR);
      default:         step_ptr = p;
    endcase
  endfunction
  wire [20:0] ptr_next = step_ptr(ptr_q, pmode);
  // Pre-increment writes at the new pointer, others at the old
  wire [20:0] hold_addr = (pmode == `TWX_PM_PREINC) ? ptr_next : ptr_q;

  // Xor results
  wire [7:0] xl_res = w_q ^ i_instr[7:0];
  wire [7:0] xf_res = w_q ^ i_fmem_rdata;
  wire       tst_zero = (i_fmem_rdata == `TWX_ZERO8);

  // Pointer, hold write and illegal report
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      ptr_q     <= `TWX_PTR_RST;
      hold_q    <= '0;
      illegal_q <= 1'b0;
    end
    else
    begin
      hold_q.wr <= 1'b0;
      illegal_q <= 1'b0;
      if (op == TWX_OP_TABWR)
      begin
        // Refused write leaves pointer and holding register alone
        if (tw_ok)
        begin
          ptr_q       <= ptr_next;
          hold_q.wr   <= 1'b1;
          hold_q.addr <= hold_addr;
          hold_q.data <= i_table_latch;
        end
        else
          illegal_q <= 1'b1;
      end
    end
  end

  // Working register and flags
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      w_q <= `TWX_W_RST;
      n_q <= 1'b0;
      z_q <= 1'b0;
    end
    else if (op == TWX_OP_XORL)
    begin
      w_q <= xl_res;
      n_q <= xl_res[7];
      z_q <= (xl_res == `TWX_ZERO8);
    end
    else if (op == TWX_OP_XORF)
    begin
      // Destination 0 to W, 1 back to the file register
      if (!d_fld)
        w_q <= xf_res;
      n_q <= xf_res[7];
      z_q <= (xf_res == `TWX_ZERO8);
    end
  end

  // File register write-back
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      fmem_q <= '0;
    else
    begin
      fmem_q.wr   <= (op == TWX_OP_XORF) && d_fld;
      fmem_q.addr <= faddr;
      fmem_q.data <= xf_res;
    end
  end

  // Second cycle: table write only when permitted, test only when zero
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      busy_q  <= 1'b0;
      flush_q <= 1'b0;
    end
    else
    begin
      flush_q <= (op == TWX_OP_TST) && tst_zero;
      busy_q  <= ((op == TWX_OP_TST) && tst_zero) ||
                 ((op == TWX_OP_TABWR) && tw_ok);
    end
  end

  assign o_table_pointer = ptr_q;
  assign o_working_reg   = w_q;
  assign o_flag_n        = n_q;
  assign o_flag_z        = z_q;
  assign o_flush         = flush_q;
  assign o_busy          = busy_q;
  assign o_illegal       = illegal_q;
  assign o_fmem          = fmem_q;
  assign o_hold          = hold_q;

  // Zero test flushes next cycle and stalls exactly one cycle
  a_skip_flush: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (op == TWX_OP_TST && tst_zero) |=> (o_flush && o_busy) ##1 !o_busy)
    else $error("zero test did not flush one cycle");
  a_skip_none: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (op == TWX_OP_TST && !tst_zero) |=> !o_flush)
    else $error("nonzero test flushed");
  a_tw_refuse: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (op == TWX_OP_TABWR && !tw_ok) |=> (!o_hold.wr && o_illegal && $stable(ptr_q)))
    else $error("refused table write acted");
  a_tw_post: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (op == TWX_OP_TABWR && tw_ok && pmode == `TWX_PM_POSTINC)
    |=> (o_hold.addr == $past(ptr_q) && ptr_q == $past(ptr_q) + `TWX_ONE_PTR))
    else $error("post-increment order wrong");
  a_tw_pre: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (op == TWX_OP_TABWR && tw_ok && pmode == `TWX_PM_PREINC)
    |=> (o_hold.addr == ptr_q && ptr_q == $past(ptr_q) + `TWX_ONE_PTR))
    else $error("pre-increment order wrong");
  a_tw_dec: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (op == TWX_OP_TABWR && tw_ok && pmode == `TWX_PM_POSTDEC)
    |=> (ptr_q == $past(ptr_q) - `TWX_ONE_PTR && o_hold.data == $past(i_table_latch)))
    else $error("post-decrement wrong");
  a_xorl_w: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (op == TWX_OP_XORL) |=> (o_working_reg == ($past(w_q) ^ $past(i_instr[7:0]))))
    else $error("literal xor result wrong");
  a_xorf_dst: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (op == TWX_OP_XORF && d_fld) |=> (o_fmem.wr && $stable(w_q)
      && o_flag_z == (o_fmem.data == `TWX_ZERO8)))
    else $error("register xor destination wrong");
  a_bank_sel: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (issue && a_fld) |-> (faddr == {i_bank_select_reg, f_fld}))
    else $error("banked address wrong");
  a_acc_bank: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (issue && !a_fld && !i_ext_set_en) |-> (faddr[11:8] == 4'h0 || faddr[11:8] == 4'hf))
    else $error("access bank address wrong");
endmodule
`default_nettype wire

// *** tb/twx_core_tb.sv ***
/*
  Self-checking bench for the table-write / test-skip / xor execution unit.
  Assumes the core package is compiled ahead of it; one 25 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module twx_core_tb
  import twx_pkg::*;
;
  // Clock, reset, issue
  logic        i_clock;
  logic        i_sys_rst;
  logic        i_valid;
  logic [15:0] i_instr;
  // Straps and operands
  logic        i_has_ext_bus;
  logic        i_target_external;
  logic        i_ext_set_en;
  logic [3:0]  i_bank_select_reg;
  logic [11:0] i_index_base;
  logic [7:0]  i_table_latch;
  logic [7:0]  i_fmem_rdata;
  // Observed outputs
  logic [11:0] o_fmem_raddr;
  twx_fmem_t   o_fmem;
  twx_hold_t   o_hold;
  logic [20:0] o_table_pointer;
  logic [7:0]  o_working_reg;
  logic        o_flag_n;
  logic        o_flag_z;
  logic        o_flush;
  logic        o_busy;
  logic        o_illegal;
  // Tallies
  int          fail_count;
  int          checked;
  // Address cases: instruction, extended set, expected address
  logic [15:0] ad_ins [5] = '{16'h6612, 16'h6680, 16'h6712, 16'h665f, 16'h6660};
  logic        ad_ext [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  logic [11:0] ad_exp [5] = '{12'h012, 12'hf80, 12'h512, 12'h15f, 12'hf60};

  twx_core twx_core_inst
  (
    .i_clock           (i_clock),
    .i_sys_rst         (i_sys_rst),
    .i_valid           (i_valid),
    .i_instr           (i_instr),
    .i_has_ext_bus     (i_has_ext_bus),
    .i_target_external (i_target_external),
    .i_ext_set_en      (i_ext_set_en),
    .i_bank_select_reg (i_bank_select_reg),
    .i_index_base      (i_index_base),
    .i_table_latch     (i_table_latch),
    .i_fmem_rdata      (i_fmem_rdata),
    .o_fmem_raddr      (o_fmem_raddr),
    .o_fmem            (o_fmem),
    .o_hold            (o_hold),
    .o_table_pointer   (o_table_pointer),
    .o_working_reg     (o_working_reg),
    .o_flag_n          (o_flag_n),
    .o_flag_z          (o_flag_z),
    .o_flush           (o_flush),
    .o_busy            (o_busy),
    .o_illegal         (o_illegal)
  );

  // Free-running clock, 40 ns period
  initial
  begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  // One edge, then the fixed drive offset
  task automatic step;
    begin
      @(posedge i_clock);
      #1;
    end
  endtask

  // Case-equality compare, counted
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      checked++;
      if (seen !== exp)
      begin
        fail_count++;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // Issue one instruction; returns just after the taking edge
  // Valid stays up so calls run back to back; the caller idles it
  task automatic op(input logic [15:0] ins);
    begin
      i_valid = 1'b1;
      i_instr = ins;
      step();
    end
  endtask

  // Table write with expected target and pointer; two cycles
  task automatic tw(input logic [1:0] m, input logic [20:0] a, input logic [20:0] p);
    begin
      op({14'h0003, m});
      chk(o_hold.wr, 1);
      chk(o_hold.addr, a);
      chk(o_hold.data, i_table_latch);
      chk(o_table_pointer, p);
      chk(o_busy, 1);
      step();
      chk(o_busy, 0);
      chk(o_hold.wr, 0);
    end
  endtask

  // Verdict and end of run
  task automatic results;
    begin
      if (fail_count == 0 && checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  // Watchdog, well beyond the roughly 30 cycles of tests
  initial
  begin
    #20000;
    fail_count++;
    results();
  end

  // Main sequence
  initial
  begin
    fail_count = 0;
    checked = 0;
    i_sys_rst = 1'b1;
    i_valid = 1'b0;
    i_instr = 16'h0000;
    i_has_ext_bus = 1'b1;
    i_target_external = 1'b1;
    i_ext_set_en = 1'b0;
    i_bank_select_reg = 4'h5;
    i_index_base = 12'h100;
    i_table_latch = 8'h55;
    i_fmem_rdata = 8'haf;
    repeat (2) @(posedge i_clock);
    #1;
    i_sys_rst = 1'b0;
    chk(o_working_reg, 8'h00);
    chk(o_table_pointer, 21'h000000);
    // Literal xor: sign, plain and zero results
    op(16'h0ab5);
    chk({o_working_reg, o_flag_n, o_flag_z}, {8'hb5, 2'b10});
    op(16'h0aaf);
    chk({o_working_reg, o_flag_n, o_flag_z}, {8'h1a, 2'b00});
    op(16'h0a1a);
    chk({o_working_reg, o_flag_n, o_flag_z}, {8'h00, 2'b01});
    op(16'h0ab5);
    // Register xor into W, then back into the file register
    op(16'h1820);
    chk({o_working_reg, o_flag_n, o_flag_z, o_fmem.wr}, {8'h1a, 3'b000});
    op(16'h1a20);
    chk(o_fmem, {1'b1, 12'h020, 8'hb5});
    chk({o_working_reg, o_flag_n, o_flag_z}, {8'h1a, 2'b10});
    // Operand address forming across banks and the index boundary, no issue
    i_valid = 1'b0;
    for (int k = 0; k < 5; k++)
    begin
      i_ext_set_en = ad_ext[k];
      i_instr = ad_ins[k];
      step();
      chk(o_fmem_raddr, ad_exp[k]);
    end
    i_ext_set_en = 1'b0;
    step();
    // Test-and-skip: nonzero is one cycle, zero flushes
    i_fmem_rdata = 8'h07;
    op(16'h67ff);
    chk({o_flush, o_busy}, 2'b00);
    i_fmem_rdata = 8'h00;
    op(16'h6612);
    chk({o_flush, o_busy}, 2'b11);
    // Issue during the skip cycle is ignored
    op(16'h0aff);
    chk({o_flush, o_busy}, 2'b00);
    chk(o_working_reg, 8'h1a);
    // Table write pointer modes
    tw(2'h1, 21'h000000, 21'h000001);
    i_table_latch = 8'h34;
    tw(2'h3, 21'h000002, 21'h000002);
    tw(2'h0, 21'h000002, 21'h000002);
    tw(2'h2, 21'h000002, 21'h000001);
    // Refused without external bus, then without external target
    i_has_ext_bus = 1'b0;
    op(16'h000d);
    chk({o_illegal, o_hold.wr, o_busy}, 3'b100);
    chk(o_table_pointer, 21'h000001);
    i_has_ext_bus = 1'b1;
    i_target_external = 1'b0;
    op(16'h000d);
    chk({o_illegal, o_hold.wr, o_busy}, 3'b100);
    chk(o_table_pointer, 21'h000001);
    i_valid = 1'b0;
    step();
    chk(o_illegal, 0);
    results();
  end
endmodule
`default_nettype wire
